// ### hdl/plh_regs.svh
/*
  Constants for the link-side transmit handover and power-status control.
  Assumes inclusion by bare name from design files; definitions only.
*/
`ifndef PLH_REGS_SVH
`define PLH_REGS_SVH
// ----------------------------------------------------------------
// Control line codes
// ----------------------------------------------------------------
`define PLH_CODE_IDLE     2'h0
`define PLH_CODE_HOLD     2'h1
`define PLH_CODE_XMIT     2'h2
`define PLH_CODE_GRANT    2'h3
// ----------------------------------------------------------------
// Timing (clock 250 MHz, period 4 ns)
// ----------------------------------------------------------------
`define PLH_CLK_PERIOD_PS     4000
`define PLH_RESET_DETECT_NS   2600
`define PLH_DISABLE_DETECT_NS 26030
`define PLH_RESTORE_FAST_NS   60
`define PLH_RESTORE_SLOW_US   5300
// Least times round up
`define PLH_RESET_CYCLES   ((`PLH_RESET_DETECT_NS * 1000 + `PLH_CLK_PERIOD_PS - 1) / `PLH_CLK_PERIOD_PS)
`define PLH_DISABLE_CYCLES ((`PLH_DISABLE_DETECT_NS * 1000 + `PLH_CLK_PERIOD_PS - 1) / `PLH_CLK_PERIOD_PS)
// Longest time rounds down
`define PLH_FAST_CYCLES    ((`PLH_RESTORE_FAST_NS * 1000) / `PLH_CLK_PERIOD_PS)
// Cycles per microsecond first, so the product stays inside 32 bits
`define PLH_SLOW_CYCLES    (`PLH_RESTORE_SLOW_US * (1000000 / `PLH_CLK_PERIOD_PS))
`define PLH_HOLD_MAX       47
`endif

// ### hdl/plh_pkg.sv
/*
  Types for the transmit handover and power-status control block.
  Assumes plh_regs.svh supplies the numeric constants.
*/
package plh_pkg;
  typedef enum logic [5:0] {
    PLH_ST_OFF    = 6'h01,
    PLH_ST_IDLE   = 6'h02,
    PLH_ST_GRANT  = 6'h04,
    PLH_ST_GIDLE  = 6'h08,
    PLH_ST_LINK   = 6'h10,
    PLH_ST_REGAIN = 6'h20
  } plh_state_t;

  typedef struct packed {
    logic [1:0] code;
    logic [7:0] data;
  } plh_word_t;
endpackage : plh_pkg

// ### hdl/plh_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module plh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             rst_n,    // Sync reset
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  input  wire logic [WIDTH-1:0] in_data,  // Write word
  output logic                  out_valid,// Not empty
  input  wire logic             out_ready,// Read accept
  output logic      [WIDTH-1:0] out_data  // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_reg != rd_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_reg[AW-1:0]] <= in_data;
  end
endmodule : plh_fifo

// ### hdl/plh_ctrl.sv
/*
  Device-side handover of the parallel interface to the link for transmit,
  with interface reset and disable driven by link_power_status.
  Assumes the link keeps its own protocol duties; all pins arrive
  asynchronous and are synchronised here. The interface clock is made
  by a divide-by-two of clk_sys and gated off while disabled.
*/
// Operation
// - Device drives idle one clock after idle
// - One turnaround clock on direction change
// - Grant, one idle, then tri-state
// - Device drives idle after regaining interface
// - Not operational: drop requests, ignore line
// - Status while down discarded, not queued
// - Reset interface after 2.6 us low
// - Disable interface after 26.03 us low
// - Reset state: outputs zero, ignore requests
// - Clock restart 60 ns or 5.3 ms
// - Codes idle 0 hold 1 xmit 2 grant 3
// - Multispeed only when enable bit set
// - Disable: outputs as reset, stop clock
`timescale 1ns/100ps
`include "plh_regs.svh"
module plh_ctrl
  import plh_pkg::*;
#(
  parameter int DISABLE_CYCLES = `PLH_DISABLE_CYCLES,
  parameter int SLOW_CYCLES    = `PLH_SLOW_CYCLES,
  parameter int FIFO_DEPTH     = 32
) (
  input  wire logic       clk_sys,                  // 250 MHz clock
  input  wire logic       rst_n,                    // Sync reset, low
  input  wire logic       link_power_status,        // Pin, async
  input  wire logic       link_request_line,        // Pin, async
  input  wire logic [1:0] handshake_code_lines_i,   // Control pins in
  output logic      [1:0] handshake_code_lines_o,   // Control pins out
  output logic            handshake_code_lines_oe,  // Control drive
  input  wire logic [7:0] data_lines_i,             // Data pins in
  output logic      [7:0] data_lines_o,             // Data pins out
  output logic            data_lines_oe,            // Data drive
  output logic            interface_clock_out,      // Interface clock
  input  wire logic       multispeed_concat_enable, // Config bit
  input  wire logic       low_power,                // Slow restore
  input  wire logic       arb_won,                  // Serial bus won
  output logic            bus_request,              // Request to arbiter
  input  wire logic       status_pending,           // Status to send
  output logic            status_drop,              // Status discarded
  output logic            tx_valid,                 // Packet byte out
  input  wire logic       tx_ready,                 // Sink ready
  output logic      [7:0] tx_data,                  // Packet byte
  output logic            tx_concat,                // Concat requested
  output logic      [7:0] tx_speed,                 // Next speed code
  output logic            if_operational            // Interface up
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    plh_state_t state;
    logic [2:0] lps_s;
    logic [1:0] req_s;
    logic [1:0] code_s1;
    logic [1:0] code_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic [1:0] prev_code;
    logic [1:0] link_cyc;
    logic [23:0] low_cnt;
    logic [23:0] rst_cnt;
    logic       if_reset;
    logic       if_disabled;
    logic       clk_div;
    logic       req_pend;
    logic       concat;
    logic [7:0] speed;
    plh_word_t  out;
    logic       oe;
  } plh_regs_t;

  plh_regs_t r_reg;
  plh_regs_t r_next;
  logic      fifo_ready;
  logic      push;

  // Link data bytes in transmit are buffered toward the serial side
  assign push = (r_reg.state == PLH_ST_LINK) && (r_reg.code_s2 == `PLH_CODE_XMIT);

  plh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (r_reg.dat_s2),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic lps_now;
    logic lps_rise;
    lps_now  = 1'b0;
    lps_rise = 1'b0;
    r_next = r_reg;
    r_next.lps_s   = {r_reg.lps_s[1:0], link_power_status};
    r_next.req_s   = {r_reg.req_s[0], link_request_line};
    r_next.code_s1 = handshake_code_lines_i;
    r_next.code_s2 = r_reg.code_s1;
    r_next.dat_s1  = data_lines_i;
    r_next.dat_s2  = r_reg.dat_s1;
    lps_now  = r_reg.lps_s[1];
    lps_rise = r_reg.lps_s[1] && !r_reg.lps_s[2];
    if (lps_now) r_next.low_cnt = '0;
    else if (r_reg.low_cnt != 24'hFFFFFF) r_next.low_cnt = r_reg.low_cnt + 24'h1;
    if (!lps_now && r_reg.low_cnt == 24'(`PLH_RESET_CYCLES)) r_next.if_reset = 1'b1;
    if (!lps_now && r_reg.low_cnt == 24'(DISABLE_CYCLES)) r_next.if_disabled = 1'b1;
    if (lps_rise && r_reg.if_reset) begin
      r_next.rst_cnt = (r_reg.if_disabled && low_power) ? 24'(SLOW_CYCLES) :
                       24'(`PLH_FAST_CYCLES);
    end else if (r_reg.if_reset && lps_now) begin
      if (r_reg.rst_cnt > 24'h1) r_next.rst_cnt = r_reg.rst_cnt - 24'h1;
      else begin
        r_next.if_reset    = 1'b0;
        r_next.if_disabled = 1'b0;
        r_next.rst_cnt     = '0;
      end
    end
    r_next.clk_div = r_reg.if_disabled ? 1'b0 : !r_reg.clk_div;
    r_next.prev_code = r_reg.code_s2;
    // Zero the pins on the very edge that reset is entered
    if (r_next.if_reset) begin
      r_next.state    = PLH_ST_OFF;
      r_next.req_pend = 1'b0;
      r_next.out = '0;
      r_next.oe  = 1'b1;
    end else begin
      if (r_reg.req_s[1]) r_next.req_pend = 1'b1;
      case (r_reg.state)
        PLH_ST_OFF: begin
          r_next.state = PLH_ST_IDLE;
          r_next.out   = '0;
          r_next.oe    = 1'b1;
        end
        PLH_ST_IDLE: begin
          r_next.out.code = `PLH_CODE_IDLE;
          r_next.out.data = '0;
          r_next.oe       = 1'b1;
          if (r_reg.req_pend && arb_won) begin
            r_next.state    = PLH_ST_GRANT;
            r_next.out.code = `PLH_CODE_GRANT;
            r_next.req_pend = 1'b0;
          end
        end
        PLH_ST_GRANT: begin
          r_next.state    = PLH_ST_GIDLE;
          r_next.out.code = `PLH_CODE_IDLE;
        end
        PLH_ST_GIDLE: begin
          r_next.state    = PLH_ST_LINK;
          r_next.oe       = 1'b0;
          r_next.out      = '0;
          r_next.link_cyc = '0;
        end
        PLH_ST_LINK: begin
          if (r_reg.code_s2 == `PLH_CODE_HOLD && r_reg.prev_code == `PLH_CODE_XMIT) begin
            r_next.concat = 1'b1;
            if (multispeed_concat_enable) r_next.speed = r_reg.dat_s2;
          end
          // Own handover idle and the link's optional idle must not count as release
          if (r_reg.link_cyc != 2'h3) r_next.link_cyc = r_reg.link_cyc + 2'h1;
          if (r_reg.link_cyc == 2'h3 && r_reg.code_s2 == `PLH_CODE_IDLE &&
              (r_reg.prev_code == `PLH_CODE_IDLE ||
               (r_reg.prev_code == `PLH_CODE_HOLD && r_reg.concat))) begin
            r_next.state = PLH_ST_REGAIN;
            r_next.oe    = 1'b1;
            r_next.out   = '0;
          end
        end
        PLH_ST_REGAIN: begin
          // At least one idle after regain
          r_next.state  = PLH_ST_IDLE;
          r_next.concat = 1'b0;
          if (r_reg.concat) r_next.req_pend = 1'b1;
        end
        default: begin
          r_next.state = PLH_ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg <= '{state: PLH_ST_OFF, if_reset: 1'b1, if_disabled: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign handshake_code_lines_o  = r_reg.out.code;
  assign data_lines_o            = r_reg.out.data;
  assign handshake_code_lines_oe = r_reg.oe;
  assign data_lines_oe           = r_reg.oe;
  assign interface_clock_out     = r_reg.clk_div;
  assign bus_request             = r_reg.req_pend;
  assign status_drop             = r_reg.if_reset && status_pending;
  assign tx_concat               = r_reg.concat;
  assign tx_speed                = r_reg.speed;
  assign if_operational          = !r_reg.if_reset;
endmodule : plh_ctrl

// ### verif/plh_link_model.sv
/* Link-side partner: answers each grant with one scripted bus ownership.
   Assumes the bench resolves the control wire from both drivers. */
`timescale 1ns/100ps
module plh_link_model (
  input  wire logic       clk_sys,  // Clock
  input  wire logic [1:0] code_w,   // Control wire
  input  wire logic [5:0] n_hold,   // Hold cycles
  input  wire logic [5:0] n_byte,   // Bytes, 0 cancels
  input  wire logic       opt_idle, // Leading idle
  input  wire logic       concat,   // End with hold
  input  wire logic [7:0] base,     // First byte
  output logic      [1:0] code_o,   // Control drive
  output logic      [7:0] data_o    // Data drive
);
  logic [9:0] q[$];
  task automatic put(input logic [1:0] c, input logic [7:0] d);
    q.push_back({c, d});
  endtask : put
  initial begin
    code_o = 2'h1;
    data_o = 8'h00;
    forever begin
      @(posedge clk_sys);
      if (code_w == 2'h3 && q.size() == 0) begin
        // Take the lines after the handover idle
        @(posedge clk_sys);
        if (opt_idle) put(2'h0, 8'h00);
        repeat (n_hold) put(2'h1, 8'h00);
        // Data, then terminator, S400 code only
        for (int i = 0; i < n_byte; i++) put(2'h2, base + 8'(i));
        if (n_byte != 0) put(concat ? 2'h1 : 2'h0, concat ? 8'h50 : 8'h00);
        // Cancel: two idles, three when nothing came before
        if (n_byte == 0) put(2'h0, 8'h00);
        if (n_byte == 0 && n_hold == 0 && !opt_idle) put(2'h0, 8'h00);
        put(2'h0, 8'h00);
      end
      // Released lines keep moving so no stale level can pass for a code
      if (q.size() != 0) {code_o, data_o} <= q.pop_front();
      else begin
        code_o <= code_o ^ 2'h1;
        data_o <= ~data_o;
      end
    end
  end
endmodule : plh_link_model

// ### verif/plh_ctrl_chk.sv
/* Port checker for plh_ctrl, bound after the module.
   Assumes one clock and rst_n synchronous, active low. */
`timescale 1ns/100ps
module plh_ctrl_chk #(
  parameter int DISABLE_CYCLES = 6508
) (
  input wire logic       clk_sys,                 // Clock
  input wire logic       rst_n,                   // Reset
  input wire logic       link_power_status,       // Power
  input wire logic [1:0] handshake_code_lines_i,  // Code in
  input wire logic [1:0] handshake_code_lines_o,  // Code out
  input wire logic       handshake_code_lines_oe, // Drive
  input wire logic [7:0] data_lines_o,            // Data out
  input wire logic       interface_clock_out,     // Clock out
  input wire logic       bus_request,             // Request
  input wire logic       status_pending,          // Status
  input wire logic       status_drop,             // Dropped
  input wire logic       if_operational           // Up
);
  wire         oe = handshake_code_lines_oe;
  wire   [1:0] co = handshake_code_lines_o;
  wire   [1:0] ci = handshake_code_lines_i;
  logic [15:0] low_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Low time at the pin; the design's synchroniser adds a few cycles
  always_ff @(posedge clk_sys) begin
    if (!rst_n || link_power_status) low_reg <= 16'h0000;
    else if (low_reg != 16'hFFFF) low_reg <= low_reg + 16'h0001;
  end
  grant_hand_a: assert property (oe && co == 2'h3 |=> oe && co == 2'h0 ##1 !oe)
    else $error("grant not followed by idle and release");
  out_zero_a: assert property (!if_operational |-> co == 2'h0 && data_lines_o == 8'h00)
    else $error("outputs not zero in reset");
  drop_status_a: assert property (status_drop == (status_pending && !if_operational))
    else $error("status drop wrong");
  req_cancel_a: assert property ($past(!if_operational) && !if_operational |-> !bus_request)
    else $error("request kept while down");
  reset_window_a: assert property ($fell(if_operational) |-> low_reg >= 650 && low_reg <= 675)
    else $error("reset outside its window");
  reset_late_a: assert property (low_reg == 16'd675 |-> !if_operational)
    else $error("reset missed");
  clock_stop_a: assert property (low_reg >= DISABLE_CYCLES + 8 |-> !interface_clock_out)
    else $error("clock not stopped");
  regain_idle_a: assert property ($rose(oe) && if_operational |-> co == 2'h0)
    else $error("regain without idle");
  link_release_a: assert property (!oe && ci == 2'h0 ##1 !oe && ci == 2'h0 |-> ##[1:4] oe)
    else $error("interface not taken back");
  cover property (oe && co == 2'h3);
  cover property ($fell(if_operational));
  cover property (low_reg == DISABLE_CYCLES + 8);
endmodule : plh_ctrl_chk
bind plh_ctrl plh_ctrl_chk #(.DISABLE_CYCLES(DISABLE_CYCLES)) plh_ctrl_chk_inst (.clk_sys,
  .rst_n, .link_power_status, .handshake_code_lines_i, .handshake_code_lines_o,
  .handshake_code_lines_oe, .data_lines_o, .interface_clock_out, .bus_request,
  .status_pending, .status_drop, .if_operational);

// ### verif/phy_link_tx_handover_lps_control_test.sv
/* Self-checking bench for plh_ctrl beside a link partner model.
   Assumes shortened disable and slow-restore counts set at the instance. */
`timescale 1ns/100ps
module phy_link_tx_handover_lps_control_test;
  logic clk_sys, rst_n, link_power_status, link_request_line, multispeed_concat_enable;
  logic low_power, arb_won, status_pending, stall, k, oi, cc, tx_ready = 1'b0;
  logic handshake_code_lines_oe, data_lines_oe, interface_clock_out, bus_request;
  logic status_drop, tx_valid, tx_concat, if_operational;
  logic [1:0] handshake_code_lines_o, lk_code;
  logic [7:0] data_lines_o, lk_data, tx_data, tx_speed, bs, rx_q[$];
  logic [5:0] nh, nb;
  logic [31:0] seed_reg = 32'hB0CB;
  int miscompares, check_count, cyc, i;
  wire [1:0] handshake_code_lines_i = handshake_code_lines_oe ? handshake_code_lines_o : lk_code;
  wire [7:0] data_lines_i = data_lines_oe ? data_lines_o : lk_data;
  plh_ctrl #(.DISABLE_CYCLES(900), .SLOW_CYCLES(50)) plh_ctrl_inst (.clk_sys, .rst_n,
    .link_power_status, .link_request_line, .handshake_code_lines_i, .handshake_code_lines_o,
    .handshake_code_lines_oe, .data_lines_i, .data_lines_o, .data_lines_oe, .interface_clock_out,
    .multispeed_concat_enable, .low_power, .arb_won, .bus_request, .status_pending, .status_drop,
    .tx_valid, .tx_ready, .tx_data, .tx_concat, .tx_speed, .if_operational);
  plh_link_model plh_link_model_inst (.clk_sys, .code_w(handshake_code_lines_i), .n_hold(nh),
    .n_byte(nb), .opt_idle(oi), .concat(cc), .base(bs), .code_o(lk_code), .data_o(lk_data));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] exp_byte(input logic [7:0] b, input int n);
    return b + 8'(n);
  endfunction : exp_byte
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Random sink stalls exercise the buffer; a hang ends the run as a mismatch
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    seed_reg <= xs(seed_reg);
    tx_ready <= !stall && seed_reg[0];
    if (tx_valid === 1'b1 && tx_ready) rx_q.push_back(tx_data);
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic xfer(input logic [5:0] h, input logic [5:0] b, input logic o, input logic c);
    @(posedge clk_sys);
    {nh, nb, oi, cc, bs} <= {h, b, o, c, seed_reg[7:0]};
    link_request_line <= 1'b1;
    arb_won <= 1'b1;
    rx_q.delete();
    for (i = 0; i < 300 && !(handshake_code_lines_oe && handshake_code_lines_o == 2'h3); i++)
      @(negedge clk_sys);
    chk(handshake_code_lines_o === 2'h3, "no grant");
    @(posedge clk_sys);
    link_request_line <= 1'b0;
    arb_won <= 1'b0;
    for (i = 0; i < 300 && handshake_code_lines_oe !== 1'b0; i++) @(negedge clk_sys);
    for (i = 0; i < 300 && handshake_code_lines_oe !== 1'b1; i++) @(negedge clk_sys);
    chk(handshake_code_lines_oe === 1'b1 && handshake_code_lines_o === 2'h0, "no regain");
    if (c) chk(tx_concat === 1'b1 && tx_speed === 8'h50, "concat speed");
    if (stall) chk(rx_q.size() == 0 && tx_valid === 1'b1, "stalled buffer");
    stall = 1'b0;
    for (i = 0; i < 300 && rx_q.size() < b; i++) @(negedge clk_sys);
    chk(rx_q.size() == b, "byte count");
    foreach (rx_q[n]) chk(rx_q[n] === exp_byte(bs, n), "byte value");
    $display("test transfer hold %0d bytes %0d done", h, b);
  endtask : xfer
  initial begin
    {rst_n, link_power_status, link_request_line, arb_won} = 4'b0100;
    {multispeed_concat_enable, low_power, status_pending, stall} = 4'b1000;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(handshake_code_lines_o === 2'h0 && data_lines_o === 8'h00, "reset outputs");
    for (i = 0; i < 200 && if_operational !== 1'b1; i++) @(negedge clk_sys);
    chk(if_operational === 1'b1, "not up");
    xfer(6'd0, 6'd1, 1'b0, 1'b0);
    xfer(6'd47, 6'd5, 1'b1, 1'b0);
    xfer(6'd2, 6'd4, 1'b0, 1'b1);
    xfer(6'd0, 6'd0, 1'b0, 1'b0);
    xfer(6'd3, 6'd0, 1'b1, 1'b0);
    stall = 1'b1;
    xfer(6'd0, 6'd32, 1'b0, 1'b0);
    repeat (4) xfer(6'(seed_reg % 48), 6'(1 + seed_reg[15:8] % 20), seed_reg[20], 1'b0);
    @(posedge clk_sys);
    {link_power_status, status_pending} <= 2'b01;
    repeat (400) @(negedge clk_sys);
    chk(if_operational === 1'b1 && status_drop === 1'b0, "early reset");
    link_request_line <= 1'b1;
    repeat (300) @(negedge clk_sys);
    chk(if_operational === 1'b0 && status_drop === 1'b1, "no reset");
    k = interface_clock_out;
    @(negedge clk_sys);
    chk(interface_clock_out !== k, "clock stopped early");
    @(posedge clk_sys);
    {link_power_status, link_request_line} <= 2'b10;
    for (i = 0; i < 40 && if_operational !== 1'b1; i++) @(negedge clk_sys);
    chk(if_operational === 1'b1 && bus_request === 1'b0, "request kept");
    $display("test reset done");
    // Pulsed power status at 40 percent high keeps the link up
    repeat (20) begin
      @(posedge clk_sys);
      link_power_status <= 1'b0;
      repeat (6) @(posedge clk_sys);
      link_power_status <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(negedge clk_sys);
    chk(if_operational === 1'b1, "pulsed power status reset");
    @(posedge clk_sys);
    {link_power_status, low_power, arb_won} <= 3'b010;
    repeat (1000) @(negedge clk_sys);
    chk(interface_clock_out === 1'b0 && if_operational === 1'b0, "clock runs");
    @(posedge clk_sys);
    link_power_status <= 1'b1;
    k = 1'b0;
    repeat (40) @(negedge clk_sys) k = k | interface_clock_out;
    chk(k === 1'b0, "slow restore too early");
    for (i = 0; i < 100 && interface_clock_out !== 1'b1; i++) @(negedge clk_sys);
    chk(interface_clock_out === 1'b1, "slow restore missing");
    $display("test disable done");
    results();
  end
endmodule : phy_link_tx_handover_lps_control_test
